// >>> inc/rx_status_pkg.sv
// shared constants, register map and types of the receive status block
package rx_status_pkg;
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_CTRL3  = 8'h08;
  localparam logic [7:0] OFF_STAT1  = 8'h0c;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_BRKCTL = 8'h14;
  localparam logic [7:0] OFF_DIV    = 8'h18;

  // control_register_one bits
  localparam int C1_ENABLE = 6;
  localparam int C1_WAKE   = 3;
  localparam int C1_IDLE_COUNT_START_SELECT   = 2;
  localparam int C1_PEN    = 1;
  localparam int C1_PTY    = 0;
  localparam int C1_MODE9  = 4;
  // control_register_two bits
  localparam int C2_RXIE   = 5;
  localparam int C2_IDLE_LINE_IRQ_ENABLE   = 4;
  localparam int C2_RE     = 2;
  localparam int C2_STBY   = 1;
  // control_register_three bits
  localparam int C3_OVERRUN_IRQ_ENABLE   = 3;
  localparam int C3_NOISE_IRQ_ENABLE   = 2;
  localparam int C3_FRAMING_IRQ_ENABLE   = 1;
  localparam int C3_PARITY_IRQ_ENABLE   = 0;
  // status_register_one bits
  localparam int S1_FULL   = 5;
  localparam int S1_IDLE   = 4;
  localparam int S1_OVR    = 3;
  localparam int S1_NOISE  = 2;
  localparam int S1_FRAME  = 1;
  localparam int S1_PARITY = 0;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] DIV_RESET   = 16'h0001;
  localparam logic [3:0]  RT_PER_BIT  = 4'hf;   // last of 16 counts
  localparam logic [3:0]  RT_START_A  = 4'h2;   // rt3,rt5,rt7 zero based
  localparam logic [3:0]  RT_START_B  = 4'h4;
  localparam logic [3:0]  RT_START_C  = 4'h6;
  localparam logic [3:0]  RT_SMP_A    = 4'h7;   // rt8,rt9,rt10 zero based
  localparam logic [3:0]  RT_SMP_B    = 4'h8;
  localparam logic [3:0]  RT_SMP_C    = 4'h9;
  localparam logic [3:0]  BITS_8      = 4'h9;   // data bits + start before stop
  localparam logic [3:0]  BITS_9      = 4'ha;
  localparam logic [3:0]  IDLE_8      = 4'ha;
  localparam logic [3:0]  IDLE_9      = 4'hb;

  typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11} rx_state_e;

  typedef struct packed {
    logic full;
    logic idle;
    logic ovr;
    logic noise;
    logic frame;
    logic parity;
  } rx_flags_s;
endpackage

// >>> src/rx_status.sv
// receive side of an async serial port: sampling, status flags, standby wakeup and irq lines
`timescale 1ns/1ps
module rx_status
  import rx_status_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_pin,
  input  wire logic        stop_mode,
  input  wire logic        break_state,
  output logic             rx_irq,
  output logic             err_irq,
  output logic             wait_wakeup
);
  localparam int CLK_HZ = 40_000_000;

  logic [7:0]  control_register_one;
  logic [7:0]  control_register_two;
  logic [7:0]  control_register_three;
  logic        break_clear_flag_enable;
  logic [15:0] div_limit;
  logic [15:0] div_cnt;
  logic        oversample_clock;
  rx_flags_s   flags;
  logic [8:0]  serial_data_register;
  logic        stat_read_armed;
  logic        rx_s1;
  logic        rx_s2;
  logic        rx_prev;
  rx_state_e   state;
  logic [3:0]  rt;
  logic [3:0]  bitn;
  logic [2:0]  smp;
  logic        prev_bit;
  logic [9:0]  shift;
  logic        char_noise;
  logic [3:0]  ones_cnt;
  logic        idle_seen;
  logic        line_idle;
  logic        wr;
  logic        rd;
  logic        run;
  logic        maj;
  logic        disagree;
  logic        char_done;
  logic        idle_event;
  logic        msb;
  logic        par_bad;
  logic [3:0]  stop_pos;
  logic [3:0]  idle_len;
  logic        flag_clr;
  logic        data_read;

  assign wr        = psel && penable && pwrite;
  assign rd        = psel && penable && !pwrite;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  // stop mode stops the oversample clock and sends the receiver back to hunt but leaves registers untouched
  assign run       = control_register_one[C1_ENABLE] && control_register_two[C2_RE] && !stop_mode;
  assign stop_pos  = control_register_one[C1_MODE9] ? BITS_9 : BITS_8;
  assign idle_len  = control_register_one[C1_MODE9] ? IDLE_9 : IDLE_8;
  // the rt10 sample is still the live input when the stop bit is judged
  assign maj       = (smp[0] & smp[1]) | (smp[0] & rx_s2) | (smp[1] & rx_s2);
  assign disagree  = !((smp[1:0] == 2'b00 && !rx_s2) || (smp[1:0] == 2'b11 && rx_s2));
  // judge the stop bit once rt10 of the stop position has been taken
  assign char_done = run && state == RX_BITS && bitn == stop_pos && rt == RT_SMP_C && oversample_clock;

  // clears obey break protection; a read half armed before break finishes only afterwards
  assign flag_clr  = rd && paddr == OFF_DATA && stat_read_armed && (!break_state || break_clear_flag_enable);
  assign data_read = rd && paddr == OFF_DATA && (!break_state || break_clear_flag_enable);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      control_register_one    <= CTRL_RESET;
      control_register_three  <= CTRL_RESET;
      break_clear_flag_enable <= 1'b0;
      div_limit               <= DIV_RESET;
    end
    else if (wr)
    begin
      case (paddr)
        OFF_CTRL1:  control_register_one    <= pwdata[7:0];
        OFF_CTRL3:  control_register_three  <= pwdata[7:0];
        OFF_BRKCTL: break_clear_flag_enable <= pwdata[0];
        OFF_DIV:    div_limit               <= pwdata[15:0];
        default:    ;
      endcase
    end
  end

  // standby bit: software sets it, wake events clear it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      control_register_two <= CTRL_RESET;
    else
    begin
      if (wr && paddr == OFF_CTRL2)
        control_register_two <= pwdata[7:0];
      if (control_register_two[C2_STBY] && run)
      begin
        if (control_register_one[C1_WAKE] && char_done && msb)
          control_register_two[C2_STBY] <= 1'b0;
        else if (!control_register_one[C1_WAKE] && (idle_event || line_idle))
          control_register_two[C2_STBY] <= 1'b0;
      end
    end
  end

  // oversample enable, 16 per bit; divider sets the rate
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_cnt          <= 16'h0000;
      oversample_clock <= 1'b0;
    end
    else if (!run)
      oversample_clock <= 1'b0;
    else if (div_cnt >= div_limit)
    begin
      div_cnt          <= 16'h0000;
      oversample_clock <= 1'b1;
    end
    else
    begin
      div_cnt          <= div_cnt + 16'h0001;
      oversample_clock <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
    end
  end

  // character state machine
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state      <= RX_HUNT;
      rt         <= 4'h0;
      bitn       <= 4'h0;
      smp        <= 3'b111;
      prev_bit   <= 1'b1;
      shift      <= 10'h000;
      char_noise <= 1'b0;
      rx_prev    <= 1'b1;
    end
    else if (!run)
    begin
      state <= RX_HUNT;  // a character in flight is abandoned
      rt    <= 4'h0;
    end
    else if (oversample_clock)
    begin
      rx_prev <= rx_s2;
      case (state)
        RX_HUNT:
        begin
          // free-running while hunting so idle ones are still counted once per bit
          rt <= rt + 4'h1;
          if (rx_prev && !rx_s2)
          begin
            state      <= RX_START;
            rt         <= 4'h1;
            char_noise <= 1'b0;
            smp        <= 3'b000;
          end
        end
        RX_START:
        begin
          rt <= rt + 4'h1;
          if (rt == RT_START_A)
            smp[0] <= rx_s2;
          if (rt == RT_START_B)
            smp[1] <= rx_s2;
          if (rt == RT_START_C)
          begin
            if ((smp[0] + smp[1] + rx_s2) > 2'd1)
              state <= RX_HUNT;
            else if (smp[0] | smp[1] | rx_s2)
              char_noise <= 1'b1;
          end
          if (rt == RT_PER_BIT)
          begin
            state    <= RX_BITS;
            bitn     <= 4'h1;
            prev_bit <= 1'b0;
          end
        end
        RX_BITS:
        begin
          rt <= rt + 4'h1;
          if (rt == RT_SMP_A)
            smp[0] <= rx_s2;
          if (rt == RT_SMP_B)
            smp[1] <= rx_s2;
          if (rt == RT_SMP_C)
          begin
            if (!((smp[0] & smp[1] & rx_s2) | !(smp[0] | smp[1] | rx_s2)))
              char_noise <= 1'b1;
            prev_bit <= (smp[0] & smp[1]) | (smp[0] & rx_s2) | (smp[1] & rx_s2);
            shift    <= {(smp[0] & smp[1]) | (smp[0] & rx_s2) | (smp[1] & rx_s2), shift[9:1]};
            if (bitn == stop_pos)
              state <= RX_HUNT;
          end
          // falling edge after a good one resyncs the bit clock
          if (rt > RT_SMP_C && prev_bit && rx_prev && !rx_s2 && bitn != stop_pos)
          begin
            rt   <= 4'h1;
            bitn <= bitn + 4'h1;
          end
          else if (rt == RT_PER_BIT)
            bitn <= bitn + 4'h1;
        end
        default: state <= RX_HUNT;
      endcase
    end
  end

  // msb and parity of the finished character; the stop bit is not yet shifted in
  always_comb
  begin
    msb     = shift[9];
    par_bad = 1'b0;
    if (control_register_one[C1_PEN])
    begin
      if (control_register_one[C1_MODE9])
        par_bad = ^shift[9:1] ^ control_register_one[C1_PTY];
      else
        par_bad = ^shift[9:2] ^ control_register_one[C1_PTY];
    end
  end

  // idle detection counts ones at bit rate
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ones_cnt  <= 4'h0;
      idle_seen <= 1'b0;
    end
    else if (run && oversample_clock && rt == RT_SMP_C)
    begin
      if (state == RX_START || !rx_s2)
      begin
        // idle_count_start_select 1 restarts the count at the stop bit, 0 after the start bit
        ones_cnt  <= 4'h0;
        idle_seen <= 1'b0;
      end
      else if (state == RX_BITS && bitn == stop_pos && control_register_one[C1_IDLE_COUNT_START_SELECT])
        ones_cnt <= 4'h0;
      else if (ones_cnt != idle_len)
        ones_cnt <= ones_cnt + 4'h1;
      else
        idle_seen <= 1'b1;
    end
  end
  assign idle_event = run && oversample_clock && rt == RT_SMP_C && ones_cnt == idle_len - 4'h1 && !idle_seen
                      && state == RX_HUNT;
  assign line_idle  = idle_seen;

  // status flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flags                <= '0;
      serial_data_register <= 9'h000;
      stat_read_armed      <= 1'b0;
    end
    else
    begin
      if (rd && paddr == OFF_STAT1 && (!break_state || break_clear_flag_enable))
        stat_read_armed <= 1'b1;
      else if (flag_clr)
        stat_read_armed <= 1'b0;
      if (flag_clr)
        flags <= '0;
      else if (data_read)
        flags.full <= 1'b0;
      if (char_done && !(control_register_two[C2_STBY] && !control_register_one[C1_WAKE])
          && (!control_register_two[C2_STBY] || msb))
      begin
        if (flags.full && !flag_clr && !data_read)
          flags.ovr <= 1'b1;
        else
        begin
          serial_data_register <= control_register_one[C1_MODE9] ? shift[9:1] : {1'b0, shift[9:2]};
          flags.full   <= 1'b1;
          flags.frame  <= !maj;
          flags.noise  <= char_noise | disagree;
          flags.parity <= par_bad;
        end
      end
      if (idle_event && !control_register_two[C2_STBY])
        flags.idle <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      case (paddr)
        OFF_CTRL1:  prdata <= {24'h000000, control_register_one};
        OFF_CTRL2:  prdata <= {24'h000000, control_register_two};
        OFF_CTRL3:  prdata <= {24'h000000, control_register_three};
        OFF_STAT1:  prdata <= {26'h0000000, flags};
        OFF_DATA:   prdata <= {23'h000000, serial_data_register};
        OFF_BRKCTL: prdata <= {31'h00000000, break_clear_flag_enable};
        OFF_DIV:    prdata <= {16'h0000, div_limit};
        default:    prdata <= 32'h0000_0000;
      endcase
  end

  // receiver irqs masked in standby error irq per enable
  assign rx_irq      = !control_register_two[C2_STBY] &&
                       ((flags.full && control_register_two[C2_RXIE]) ||
                        (flags.idle && control_register_two[C2_IDLE_LINE_IRQ_ENABLE]));
  assign err_irq     = (flags.ovr && control_register_three[C3_OVERRUN_IRQ_ENABLE]) ||
                       (flags.noise && control_register_three[C3_NOISE_IRQ_ENABLE]) ||
                       (flags.frame && control_register_three[C3_FRAMING_IRQ_ENABLE]) ||
                       (flags.parity && control_register_three[C3_PARITY_IRQ_ENABLE]);
  assign wait_wakeup = rx_irq || err_irq;

  full_frame_a: assert property (@(posedge clk_sys) disable iff (rst)
    char_done && !maj && !flags.full && !control_register_two[C2_STBY] |=> flags.full && flags.frame)
    else $error("framing flag not set with full flag");
  stby_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
    control_register_two[C2_STBY] |-> !rx_irq)
    else $error("receiver irq while in standby");
  err_or_a: assert property (@(posedge clk_sys) disable iff (rst)
    (flags.frame && control_register_three[C3_FRAMING_IRQ_ENABLE]) |-> err_irq)
    else $error("framing error did not raise error irq");
  overrun_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(flags.ovr) |-> $stable(serial_data_register))
    else $error("overrun replaced stored character");
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    stop_mode |=> $stable(control_register_one) && $stable(flags.full))
    else $error("registers changed in stop mode");
  brk_protect_a: assert property (@(posedge clk_sys) disable iff (rst)
    break_state && !break_clear_flag_enable && flags.full && !char_done |=> flags.full)
    else $error("flag cleared in protected break state");
  wait_wake_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_irq || err_irq) |-> wait_wakeup)
    else $error("enabled irq did not request wakeup");
  addr_wake_a: assert property (@(posedge clk_sys) disable iff (rst)
    char_done && control_register_two[C2_STBY] && control_register_one[C1_WAKE] && msb && !wr
    |=> !control_register_two[C2_STBY] && flags.full)
    else $error("address mark did not wake receiver");
endmodule

// >>> bench/serial_source.sv
// remote asynchronous transmitter model on the serial receive line
`timescale 1ns/1ps
module serial_source #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_sys,
  output logic      line
);
  // the line rests high between characters, as an idle serial input does
  initial line = 1'b1;
  // start bit, data lsb first, then a stop bit whose level the caller picks
  task automatic send(input logic [8:0] data, input int nbits, input logic stop_val);
    int i;
    @(posedge clk_sys);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (i = 0; i < nbits; i++)
    begin
      line <= data[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    line <= stop_val;
    repeat (BIT_CLKS) @(posedge clk_sys);
    line <= 1'b1;
  endtask
endmodule

// >>> bench/test_rx_status.sv
// self-checking bench of the receive status block
`timescale 1ns/1ps
module test_rx_status import rx_status_pkg::*; ;
  localparam int BIT   = 32;  // divider resets to 1: one oversample tick every two clocks
  localparam int LIMIT = 40000;
  logic        clk_sys, rst, psel, penable, pwrite, stop_mode, break_state;
  logic        pready, pslverr, rx_pin, rx_irq, err_irq, wait_wakeup;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          err_count, samples_checked;
  int          cyc = 0;
  rx_status DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .stop_mode(stop_mode), .break_state(break_state), .rx_irq(rx_irq),
    .err_irq(err_irq), .wait_wakeup(wait_wakeup));
  serial_source #(.BIT_CLKS(BIT)) src (.clk_sys(clk_sys), .line(rx_pin));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cb(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask
  // request held until pready is sampled high; read data is taken at that same edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    cb("pslverr", pslverr, 1'b0);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  // status read then data read clears every flag
  task automatic clr();
    apb(1'b0, OFF_STAT1, 32'h0);
    apb(1'b0, OFF_DATA, 32'h0);
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge clk_sys);
  endtask
  task automatic brk(input logic b);
    break_state <= b;
    @(posedge clk_sys);
  endtask
  // clocks from start edge to receive full; slack covers the input synchronizer
  task automatic timed(input logic [8:0] d, input int nb, input logic sv, input int rt);
    int k;
    k = 0;
    fork
      src.send(d, nb, sv);
      begin
        while (rx_irq !== 1'b1)
        begin
          @(posedge clk_sys);
          k++;
        end
        cb("err with full", err_irq, ~sv);
      end
    join
    cb("full delay", k >= 2 * rt - 4 && k <= 2 * rt + 12, 1'b1);
  endtask
  task automatic s_reset();
    rc("ctrl1", OFF_CTRL1, 32'h0);
    rc("ctrl2", OFF_CTRL2, 32'h0);
    rc("ctrl3", OFF_CTRL3, 32'h0);
    rc("status", OFF_STAT1, 32'h0);
    rc("brk ctl", OFF_BRKCTL, 32'h0);
    rc("divider", OFF_DIV, 32'h1);
    w(8'h1c, 32'hff);
    rc("unmapped", 8'h1c, 32'h0);
  endtask
  task automatic s_plain();
    w(OFF_CTRL1, 32'h40);
    w(OFF_CTRL3, 32'h0f);
    w(OFF_CTRL2, 32'h34);
    src.send(9'h0a5, 8, 1'b1);
    cb("rx irq", rx_irq, 1'b1);
    cb("wakeup", wait_wakeup, 1'b1);
    rc("full", OFF_STAT1, 32'h20);
    w(OFF_CTRL2, 32'h04);
    cb("rx irq masked", rx_irq, 1'b0);
    w(OFF_CTRL2, 32'h34);
    rc("data", OFF_DATA, 32'h0a5);
    rc("cleared", OFF_STAT1, 32'h0);
    bits(12);
    rc("idle", OFF_STAT1, 32'h10);
    cb("idle irq", rx_irq, 1'b1);
    clr();
  endtask
  task automatic s_frame();
    w(OFF_CTRL2, 32'h24);
    timed(9'h03c, 8, 1'b0, 154);
    rc("framing", OFF_STAT1, 32'h22);
    w(OFF_CTRL3, 32'h0);
    cb("err masked", err_irq, 1'b0);
    w(OFF_CTRL3, 32'h02);
    cb("framing irq", err_irq, 1'b1);
    w(OFF_CTRL3, 32'h0f);
    clr();
    src.send(9'h000, 8, 1'b0);
    rc("break char", OFF_STAT1, 32'h22);
    clr();
    w(OFF_CTRL1, 32'h50);
    timed(9'h1a5, 9, 1'b1, 170);
    rc("nine bit", OFF_DATA, 32'h1a5);
    w(OFF_CTRL1, 32'h40);
  endtask
  task automatic s_overrun();
    src.send(9'h011, 8, 1'b1);
    src.send(9'h022, 8, 1'b1);
    rc("overrun", OFF_STAT1, 32'h28);
    cb("overrun irq", err_irq, 1'b1);
    rc("old data", OFF_DATA, 32'h011);
  endtask
  task automatic s_parity();
    w(OFF_CTRL1, 32'h42);
    src.send(9'h001, 8, 1'b1);
    rc("parity bad", OFF_STAT1, 32'h21);
    cb("parity irq", err_irq, 1'b1);
    clr();
    src.send(9'h081, 8, 1'b1);
    rc("parity good", OFF_STAT1, 32'h20);
    clr();
    w(OFF_CTRL1, 32'h40);
  endtask
  task automatic s_standby();
    w(OFF_CTRL1, 32'h48);
    w(OFF_CTRL2, 32'h26);
    src.send(9'h005, 8, 1'b1);
    cb("standby irq", rx_irq, 1'b0);
    rc("still standby", OFF_CTRL2, 32'h26);
    clr();
    src.send(9'h085, 8, 1'b1);
    rc("mark wake", OFF_CTRL2, 32'h24);
    cb("wake irq", rx_irq, 1'b1);
    rc("wake full", OFF_STAT1, 32'h20);
    rc("wake data", OFF_DATA, 32'h085);
    w(OFF_CTRL1, 32'h40);
    w(OFF_CTRL2, 32'h26);
    bits(14);
    rc("idle wake", OFF_CTRL2, 32'h24);
    rc("idle wake flags", OFF_STAT1, 32'h0);
    w(OFF_CTRL2, 32'h26);
    bits(1);
    rc("idle at once", OFF_CTRL2, 32'h24);
  endtask
  task automatic s_stop();
    stop_mode <= 1'b1;
    bits(2);
    stop_mode <= 1'b0;
    @(posedge clk_sys);
    rc("ctrl1 kept", OFF_CTRL1, 32'h40);
    rc("ctrl3 kept", OFF_CTRL3, 32'h0f);
    src.send(9'h05a, 8, 1'b1);
    rc("resumed", OFF_DATA, 32'h05a);
  endtask
  task automatic s_brk();
    src.send(9'h066, 8, 1'b0);
    brk(1'b1);
    clr();
    rc("held in break", OFF_STAT1, 32'h22);
    brk(1'b0);
    apb(1'b0, OFF_STAT1, 32'h0);
    brk(1'b1);
    bits(1);
    brk(1'b0);
    apb(1'b0, OFF_DATA, 32'h0);
    rc("cleared after", OFF_STAT1, 32'h0);
    src.send(9'h077, 8, 1'b0);
    w(OFF_BRKCTL, 32'h1);
    brk(1'b1);
    clr();
    brk(1'b0);
    rc("cleared in break", OFF_STAT1, 32'h0);
    w(OFF_BRKCTL, 32'h0);
  endtask
  // counting after the stop bit delays idle past what counting after the start bit gives
  task automatic s_idle_count_start_select();
    bits(12);
    clr();
    w(OFF_CTRL1, 32'h44);
    src.send(9'h0ff, 8, 1'b1);
    bits(4);
    rc("no early idle", OFF_STAT1, 32'h20);
    bits(8);
    rc("late idle", OFF_STAT1, 32'h30);
    clr();
    w(OFF_CTRL1, 32'h40);
  endtask
  initial
  begin
    err_count       = 0;
    samples_checked = 0;
    {rst, psel, penable, pwrite, stop_mode, break_state} = 6'b100000;
    paddr  = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    s_reset();
    s_plain();
    s_frame();
    s_overrun();
    s_parity();
    s_standby();
    s_stop();
    s_brk();
    s_idle_count_start_select();
    wrap_up();
  end
endmodule
